// *** hdl/icsp_top.sv ***
/*
 * Host port logic: normal and management index/data windows onto the
 * configuration register file, the system control port with its parity
 * and channel-check latches, speaker drive and NMI combination.
 * Assumes host strobes and the configuration file run on clk_sys; the
 * channel-check, timer-2 and refresh pins are asynchronous.
 */
//
// Operation
// - Port 22h is a write-only index for the normal data window.
// - Data access to 23h reaches indexed register; unindexed repeat ignored.
// - Port 26h is a separate write-only management index.
// - Data access to 27h reaches management-indexed register once per index.
// - Each window keeps its own accessed flag.
// - Port 61h low nibble read/write, high nibble read-only, reset reads 20h.
// - This chip owns bits 2,3,6,7; companion supplies the rest.
// - Gate bit enables timer-2 clock; when low, timer status reads 1.
// - Speaker output is inverse of speaker data ANDed with timer output.
// - Bit 2 at 1 disables parity checking and presets parity latch.
// - Parity error clocks latch to 0 unless blocked by config bit.
// - Bit 3 at 1 clears channel-check latch; active input sets it.
// - Bit 4 toggles on every refresh request, regardless of ISA refresh.
// - Bit 5 shows timer-2 output; pattern 01 runs timer silently.
// - Bit 6 reads 1 once channel check has been asserted.
// - Bit 7 reads 1 after a local parity error.
// - CPU NMI is OR of sources ANDed with inverse of mask bit.
`timescale 1ns/1ps

module icsp_top #(
   parameter int ADDR_W = 16
) (
   input wire logic clk_sys,
   input wire logic rstn,
   input wire logic ce,
   input wire icsp_pkg::icsp_io_req_t io_req,
   output logic [7:0] io_rdata,
   output logic io_rvalid,
   output logic [7:0] io_rdata_own_mask,
   output icsp_pkg::icsp_cfg_req_t cfg_req,
   input wire logic [7:0] cfg_rdata,
   input wire logic parity_err,
   input wire logic parity_block,
   input wire logic iochck_n,
   input wire logic timer2_out,
   input wire logic refresh_req,
   output logic speaker_timer_gate,
   output logic speaker_out,
   output logic local_parity_nmi_n,
   output logic nmi
);

   // Only 16-bit I/O addressing is decoded
   generate
      if (ADDR_W != 16) begin : g_bad_addr
         $error("icsp_top: ADDR_W must be 16");
      end
   endgenerate

   // Address decode of the current host cycle
   logic hit_cfg_idx, hit_cfg_dat, hit_smm_idx, hit_smm_dat;
   logic hit_sys, hit_rtc;
   assign hit_cfg_idx = io_req.addr == icsp_pkg::ADDR_CFG_INDEX;
   assign hit_cfg_dat = io_req.addr == icsp_pkg::ADDR_CFG_DATA;
   assign hit_smm_idx = io_req.addr == icsp_pkg::ADDR_SMM_INDEX;
   assign hit_smm_dat = io_req.addr == icsp_pkg::ADDR_SMM_DATA;
   assign hit_sys = io_req.addr == icsp_pkg::ADDR_SYS_CTRL;
   assign hit_rtc = io_req.addr == icsp_pkg::ADDR_RTC_INDEX;

   logic acc;
   assign acc = io_req.rd | io_req.wr;

   // Pin synchronisers; stage 0 is read only by stage 1
   logic [2:0] sync0_q, sync1_q;
   logic refr_prev_q;
   always_ff @(posedge clk_sys) begin
      if (!rstn) begin
         sync0_q <= 3'h1;
         sync1_q <= 3'h1;
         refr_prev_q <= 1'b0;
      end else if (ce) begin
         sync0_q <= {refresh_req, timer2_out, iochck_n};
         sync1_q <= sync0_q;
         refr_prev_q <= sync1_q[2];
      end
   end

   logic chk_act, t2_sync, refr_edge;
   assign chk_act = ~sync1_q[0];
   assign t2_sync = sync1_q[1];
   assign refr_edge = sync1_q[2] & ~refr_prev_q;

   // Normal window: index and armed flag (armed = not yet accessed)
   logic [7:0] cfg_idx_q;
   logic cfg_arm_q;
   always_ff @(posedge clk_sys) begin
      if (!rstn) begin
         cfg_idx_q <= icsp_pkg::IDX_RESET;
         cfg_arm_q <= 1'b0;
      end else if (ce) begin
         if (io_req.wr && hit_cfg_idx) begin
            cfg_idx_q <= io_req.wdata;
            cfg_arm_q <= 1'b1;
         end else if (acc && hit_cfg_dat) begin
            cfg_arm_q <= 1'b0;
         end
      end
   end

   // Management window kept apart from the normal one
   logic [7:0] smm_idx_q;
   logic smm_arm_q;
   always_ff @(posedge clk_sys) begin
      if (!rstn) begin
         smm_idx_q <= icsp_pkg::IDX_RESET;
         smm_arm_q <= 1'b0;
      end else if (ce) begin
         if (io_req.wr && hit_smm_idx) begin
            smm_idx_q <= io_req.wdata;
            smm_arm_q <= 1'b1;
         end else if (acc && hit_smm_dat) begin
            smm_arm_q <= 1'b0;
         end
      end
   end

   // Forward one data access per index write to the register file
   logic cfg_go, smm_go;
   assign cfg_go = acc && hit_cfg_dat && cfg_arm_q;
   assign smm_go = acc && hit_smm_dat && smm_arm_q;
   always_ff @(posedge clk_sys) begin
      if (!rstn) begin
         cfg_req <= '0;
      end else if (ce) begin
         cfg_req.rd <= (cfg_go | smm_go) & io_req.rd;
         cfg_req.wr <= (cfg_go | smm_go) & io_req.wr;
         cfg_req.smm <= smm_go;
         cfg_req.index <= smm_go ? smm_idx_q : cfg_idx_q;
         cfg_req.wdata <= io_req.wdata;
      end
   end

   // Writable bits of the control port and the NMI mask
   logic gate_q, spk_q, par_dis_q, chk_dis_q, nmi_mask_q;
   always_ff @(posedge clk_sys) begin
      if (!rstn) begin
         gate_q <= icsp_pkg::SYS_CTRL_RESET[icsp_pkg::BIT_GATE];
         spk_q <= icsp_pkg::SYS_CTRL_RESET[icsp_pkg::BIT_SPK];
         par_dis_q <= icsp_pkg::SYS_CTRL_RESET[icsp_pkg::BIT_PAR_DIS];
         chk_dis_q <= icsp_pkg::SYS_CTRL_RESET[icsp_pkg::BIT_CHK_DIS];
         nmi_mask_q <= 1'b0;
      end else if (ce) begin
         if (io_req.wr && hit_sys) begin
            // Upper nibble is read-only; writes there are dropped
            gate_q <= io_req.wdata[icsp_pkg::BIT_GATE];
            spk_q <= io_req.wdata[icsp_pkg::BIT_SPK];
            par_dis_q <= io_req.wdata[icsp_pkg::BIT_PAR_DIS];
            chk_dis_q <= io_req.wdata[icsp_pkg::BIT_CHK_DIS];
         end
         if (io_req.wr && hit_rtc) begin
            nmi_mask_q <= io_req.wdata[icsp_pkg::BIT_NMI_MASK];
         end
      end
   end

   // Parity latch: preset by the disable bit, clocked low by an error
   logic par_q;
   always_ff @(posedge clk_sys) begin
      if (!rstn) begin
         par_q <= 1'b1;
      end else if (ce) begin
         if (par_dis_q) begin
            par_q <= 1'b1;
         end else if (parity_err && !parity_block) begin
            par_q <= 1'b0;
         end
      end
   end

   // Channel-check latch: clear held by disable bit wins over the pin
   logic chk_q;
   always_ff @(posedge clk_sys) begin
      if (!rstn) begin
         chk_q <= 1'b0;
      end else if (ce) begin
         if (chk_dis_q) begin
            chk_q <= 1'b0;
         end else if (chk_act) begin
            chk_q <= 1'b1;
         end
      end
   end

   // Refresh detect toggles on each synchronised request edge
   logic refr_q;
   always_ff @(posedge clk_sys) begin
      if (!rstn) begin
         refr_q <= 1'b0;
      end else if (ce && refr_edge) begin
         refr_q <= ~refr_q;
      end
   end

   // Timer status forced high while the gate is off
   logic t2_eff;
   assign t2_eff = gate_q ? t2_sync : 1'b1;

   // Assembled port byte; companion-owned bits are mirrored for reference
   logic [7:0] sys_byte;
   always_comb begin
      sys_byte = '0;
      sys_byte[icsp_pkg::BIT_GATE] = gate_q;
      sys_byte[icsp_pkg::BIT_SPK] = spk_q;
      sys_byte[icsp_pkg::BIT_PAR_DIS] = par_dis_q;
      sys_byte[icsp_pkg::BIT_CHK_DIS] = chk_dis_q;
      sys_byte[icsp_pkg::BIT_REFRESH] = refr_q;
      sys_byte[icsp_pkg::BIT_T2_OUT] = t2_eff;
      sys_byte[icsp_pkg::BIT_CHCK] = chk_q;
      sys_byte[icsp_pkg::BIT_PARERR] = ~par_q;
   end

   // Pin outputs, all registered
   always_ff @(posedge clk_sys) begin
      if (!rstn) begin
         speaker_timer_gate <= 1'b0;
         speaker_out <= 1'b1;
         local_parity_nmi_n <= 1'b1;
         nmi <= 1'b0;
      end else if (ce) begin
         speaker_timer_gate <= gate_q;
         speaker_out <= ~(spk_q & t2_eff);
         local_parity_nmi_n <= par_q;
         nmi <= (~par_q | chk_q) & ~nmi_mask_q;
      end
   end

   // Read pipeline: stage one picks the source, stage two returns data.
   // Two cycles for every answered read so the file has a full cycle to answer.
   icsp_pkg::icsp_rd_src_t rd_src_q;
   always_ff @(posedge clk_sys) begin
      if (!rstn) begin
         rd_src_q <= icsp_pkg::ICSP_RD_NONE;
      end else if (ce) begin
         if (!io_req.rd) begin
            rd_src_q <= icsp_pkg::ICSP_RD_NONE;
         end else if (cfg_go) begin
            rd_src_q <= icsp_pkg::ICSP_RD_CFG;
         end else if (smm_go) begin
            rd_src_q <= icsp_pkg::ICSP_RD_SMM;
         end else if (hit_sys) begin
            rd_src_q <= icsp_pkg::ICSP_RD_SYS;
         end else if (hit_cfg_dat || hit_smm_dat) begin
            rd_src_q <= icsp_pkg::ICSP_RD_DEAD;
         end else begin
            rd_src_q <= icsp_pkg::ICSP_RD_NONE;
         end
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!rstn) begin
         io_rdata <= icsp_pkg::READ_IDLE;
         io_rvalid <= 1'b0;
         io_rdata_own_mask <= '0;
      end else if (ce) begin
         case (rd_src_q)
            icsp_pkg::ICSP_RD_CFG,
            icsp_pkg::ICSP_RD_SMM: begin
               io_rdata <= cfg_rdata;
               io_rvalid <= 1'b1;
               io_rdata_own_mask <= '1;
            end
            icsp_pkg::ICSP_RD_SYS: begin
               io_rdata <= sys_byte;
               io_rvalid <= 1'b1;
               io_rdata_own_mask <= icsp_pkg::SYS_CTRL_OWN_MASK;
            end
            icsp_pkg::ICSP_RD_DEAD: begin
               io_rdata <= icsp_pkg::READ_IDLE;
               io_rvalid <= 1'b1;
               io_rdata_own_mask <= '1;
            end
            icsp_pkg::ICSP_RD_NONE: begin
               io_rdata <= icsp_pkg::READ_IDLE;
               io_rvalid <= 1'b0;
               io_rdata_own_mask <= '0;
            end
            default: begin
               io_rdata <= icsp_pkg::READ_IDLE;
               io_rvalid <= 1'b0;
               io_rdata_own_mask <= '0;
            end
         endcase
      end
   end

   // Checks on the behaviour above
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rstn);

   AST_DEAD_ACCESS: assert property (
      ce && acc && hit_cfg_dat && !cfg_arm_q |=> !cfg_req.rd && !cfg_req.wr)
      else $error("repeated data access was forwarded");

   AST_ONE_SHOT: assert property (
      ce && io_req.rd && hit_cfg_dat && cfg_arm_q
      |=> cfg_req.rd && cfg_req.index == $past(cfg_idx_q) && !cfg_arm_q)
      else $error("first data read not forwarded once");

   AST_INDEX_ARMS: assert property (
      ce && io_req.wr && hit_cfg_idx |=> cfg_arm_q)
      else $error("index write did not arm window");

   AST_WINDOWS_APART: assert property (
      ce && acc && hit_cfg_dat |=> smm_arm_q == $past(smm_arm_q))
      else $error("normal access changed management flag");

   AST_SMM_INDEX: assert property (
      ce && io_req.wr && hit_smm_dat && smm_arm_q
      |=> cfg_req.wr && cfg_req.smm && cfg_req.index == $past(smm_idx_q))
      else $error("management access used wrong index");

   AST_PAR_PRESET: assert property (
      ce && par_dis_q |=> par_q)
      else $error("parity latch not held preset");

   AST_CHK_CLEAR: assert property (
      ce && chk_dis_q |=> !chk_q)
      else $error("channel-check latch not held clear");

   AST_SPEAKER: assert property (
      ce && spk_q && !gate_q |=> !speaker_out)
      else $error("speaker not driven low by data with gate off");

   AST_NMI_MASK: assert property (
      ce && nmi_mask_q |=> !nmi)
      else $error("masked NMI reached CPU");

   AST_REFRESH: assert property (
      ce && refr_edge |=> refr_q != $past(refr_q))
      else $error("refresh detect did not toggle");

   AST_SYS_READ: assert property (
      ce && io_req.rd && hit_sys ##1 ce
      |=> io_rvalid && io_rdata[icsp_pkg::BIT_PARERR] == ~$past(par_q))
      else $error("parity error bit read wrongly");

endmodule // icsp_top

// *** hdl/icsp_pkg.sv ***
/*
 * Package for the indexed configuration windows and the system control
 * port: I/O addresses, bit positions, reset values, timing figures and
 * the request carriers.
 * Assumes one 25 MHz clock domain and byte-wide host I/O cycles.
 */
package icsp_pkg;

   // I/O port addresses
   localparam logic [15:0] ADDR_CFG_INDEX = 16'h0022;
   localparam logic [15:0] ADDR_CFG_DATA = 16'h0023;
   localparam logic [15:0] ADDR_SMM_INDEX = 16'h0026;
   localparam logic [15:0] ADDR_SMM_DATA = 16'h0027;
   localparam logic [15:0] ADDR_SYS_CTRL = 16'h0061;
   localparam logic [15:0] ADDR_RTC_INDEX = 16'h0070;

   // System control port bit positions and the NMI mask bit
   localparam int BIT_GATE = 0;
   localparam int BIT_SPK = 1;
   localparam int BIT_PAR_DIS = 2;
   localparam int BIT_CHK_DIS = 3;
   localparam int BIT_REFRESH = 4;
   localparam int BIT_T2_OUT = 5;
   localparam int BIT_CHCK = 6;
   localparam int BIT_PARERR = 7;
   localparam int BIT_NMI_MASK = 7;

   // Reset values and read masks
   localparam logic [7:0] SYS_CTRL_RESET = 8'h20;
   localparam logic [7:0] SYS_CTRL_OWN_MASK = 8'hCC;
   localparam logic [7:0] IDX_RESET = 8'h00;
   localparam logic [7:0] READ_IDLE = 8'hFF;

   // Timing: system clock and refresh request period
   localparam int CLK_NS = 40;
   localparam int REFRESH_NS = 15000;
   localparam int REFRESH_CYC = REFRESH_NS / CLK_NS;

   // Source of the byte returned on a read
   typedef enum logic [2:0] {
      ICSP_RD_NONE = 3'b000,
      ICSP_RD_CFG = 3'b001,
      ICSP_RD_SMM = 3'b010,
      ICSP_RD_SYS = 3'b011,
      ICSP_RD_DEAD = 3'b100
   } icsp_rd_src_t;

   // Host I/O cycle, one-cycle strobes
   typedef struct packed {
      logic rd;
      logic wr;
      logic [15:0] addr;
      logic [7:0] wdata;
   } icsp_io_req_t;

   // Access to the internal configuration register file
   typedef struct packed {
      logic rd;
      logic wr;
      logic smm;
      logic [7:0] index;
      logic [7:0] wdata;
   } icsp_cfg_req_t;

endpackage

// *** verif/icsp_cfg_model.sv ***
/*
 * Behavioural configuration register file behind both index windows.
 * Assumes cfg_req strobes are one cycle wide and that the read byte is
 * wanted combinationally in the strobe cycle.
 */
`timescale 1ns/1ps

module icsp_cfg_model (
   input wire logic clk_sys,
   input wire icsp_pkg::icsp_cfg_req_t cfg_req,
   output logic [7:0] cfg_rdata
);
   logic [7:0] mem_q [0:511];
   logic [7:0] junk_q;

   // Windows map to separate halves so a cross-window slip shows up
   initial begin
      junk_q = 8'h5A;
      for (int i = 0; i < 512; i++) mem_q[i] = 8'h00;
   end

   // Writes land on the edge; junk pattern moves every cycle
   // Plain always: the initial block above also writes these variables
   always @(posedge clk_sys) begin
      junk_q <= ~junk_q + 8'h01;
      if (cfg_req.wr) mem_q[{cfg_req.smm, cfg_req.index}] <= cfg_req.wdata;
   end

   // Outside a read strobe the byte is garbage, never the last value
   always_comb begin
      cfg_rdata = cfg_req.rd ? mem_q[{cfg_req.smm, cfg_req.index}] : junk_q;
   end
endmodule // icsp_cfg_model

// *** verif/indexed_config_and_sys_port_tb.sv ***
/*
 * Self-checking bench for the host port logic: index windows, port 61,
 * latches, speaker and NMI. Assumes the partner register file model and
 * a 25 MHz clock; inputs move 1 ns after the rising edge.
 */
`timescale 1ns/1ps

module indexed_config_and_sys_port_tb;
   logic clk_sys, rstn, ce, perr, pblk, chk_n, t2, rfq;
   icsp_pkg::icsp_io_req_t req;
   icsp_pkg::icsp_cfg_req_t cfg_req;
   logic [7:0] io_rdata, mask, cfg_rdata, v, m, w, idx, d;
   logic io_rvalid, speaker_timer_gate, speaker_out;
   logic local_parity_nmi_n, nmi, got;
   logic [3:0] lo;
   logic rf, ck, pe, mk;
   int err_total, tests_run, seed;

   icsp_top dut_u (.clk_sys(clk_sys), .rstn(rstn), .ce(ce), .io_req(req),
      .io_rdata(io_rdata), .io_rvalid(io_rvalid), .io_rdata_own_mask(mask),
      .cfg_req(cfg_req), .cfg_rdata(cfg_rdata), .parity_err(perr),
      .parity_block(pblk), .iochck_n(chk_n), .timer2_out(t2),
      .refresh_req(rfq), .speaker_timer_gate(speaker_timer_gate),
      .speaker_out(speaker_out), .local_parity_nmi_n(local_parity_nmi_n),
      .nmi(nmi));
   icsp_cfg_model cfg_u (.clk_sys(clk_sys), .cfg_req(cfg_req),
      .cfg_rdata(cfg_rdata));

   // 40 ns system clock
   initial begin
      clk_sys = 1'b0;
      forever #20 clk_sys = ~clk_sys;
   end

   task automatic wrap_up;
      if (err_total == 0 && tests_run > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask

   task automatic chk(input logic [7:0] seen, exp, input string msg);
      tests_run++;
      if (seen !== exp) begin
         err_total++;
         $display("unexpected, t=%0t: %s %h vs %h", $time, msg, seen, exp);
      end
   endtask

   task automatic idle(input int n);
      repeat (n) @(posedge clk_sys);
      #1;
   endtask

   // One strobe cycle; a bus cycle is always followed by a quiet edge
   task automatic io(input logic wr, input logic [15:0] a,
      input logic [7:0] dt);
      @(posedge clk_sys);
      #1;
      req.rd = !wr;
      req.wr = wr;
      req.addr = a;
      req.wdata = dt;
      @(posedge clk_sys);
      #1;
      req.rd = 1'b0;
      req.wr = 1'b0;
   endtask

   // Read answer arrives one edge after the taking edge
   task automatic rd(input logic [15:0] a);
      int n;
      io(1'b0, a, 8'h00);
      n = 0;
      while (io_rvalid !== 1'b1 && n < 4) begin
         @(posedge clk_sys);
         #1;
         n++;
      end
      if (n == 4) begin
         err_total++;
         $display("unexpected, t=%0t: read timed out", $time);
         wrap_up();
      end
      v = io_rdata;
      m = mask;
   endtask

   function automatic logic [7:0] exp61();
      logic b5;
      b5 = lo[0] ? t2 : 1'b1;
      return {pe, ck, b5, rf, lo};
   endfunction

   function automatic logic [7:0] exp_pins();
      logic b5;
      b5 = lo[0] ? t2 : 1'b1;
      return {4'h0, lo[0], ~(lo[1] & b5), ~pe, (pe | ck) & ~mk};
   endfunction

   // Port 61 readback plus the pins it drives
   task automatic check61(input string msg);
      idle(5);
      rd(icsp_pkg::ADDR_SYS_CTRL);
      chk(v, exp61(), msg);
      chk(m, icsp_pkg::SYS_CTRL_OWN_MASK, "mask");
      chk({4'h0, speaker_timer_gate, speaker_out, local_parity_nmi_n, nmi},
          exp_pins(), msg);
   endtask

   // Main sequence
   initial begin
      seed = 99847;
      err_total = 0;
      tests_run = 0;
      rstn = 1'b0;
      ce = 1'b1;
      req = '0;
      {perr, pblk, t2, rfq, rf, ck, pe, mk, lo} = '0;
      chk_n = 1'b1;
      idle(12);
      rstn = 1'b1;
      check61("reset");
      for (int i = 0; i < 4; i++) begin
         // Only defined indexes are used, as host software must
         idx = 8'h10 | (8'($random(seed)) & 8'h07);
         d = 8'($random(seed));
         io(1'b1, icsp_pkg::ADDR_CFG_INDEX, idx);
         io(1'b1, icsp_pkg::ADDR_CFG_DATA, d);
         io(1'b1, icsp_pkg::ADDR_SMM_INDEX, idx);
         io(1'b1, icsp_pkg::ADDR_SMM_DATA, ~d);
         io(1'b1, icsp_pkg::ADDR_SMM_DATA, d);
         io(1'b1, icsp_pkg::ADDR_CFG_INDEX, idx);
         io(1'b1, icsp_pkg::ADDR_SMM_INDEX, idx);
         rd(icsp_pkg::ADDR_CFG_DATA);
         chk(v, d, "cfg read");
         chk(m, 8'hFF, "cfg mask");
         rd(icsp_pkg::ADDR_CFG_DATA);
         chk(v, icsp_pkg::READ_IDLE, "cfg repeat");
         rd(icsp_pkg::ADDR_SMM_DATA);
         chk(v, ~d, "smm read");
         rd(icsp_pkg::ADDR_SMM_DATA);
         chk(v, icsp_pkg::READ_IDLE, "smm repeat");
      end
      for (int i = 0; i < 10; i++) begin
         // First four writes walk the gate and speaker corner patterns
         w = (i < 4) ? 8'(i) : 8'($random(seed));
         t2 = 1'($random(seed));
         io(1'b1, icsp_pkg::ADDR_SYS_CTRL, w);
         lo = w[3:0];
         if (w[2]) pe = 1'b0;
         if (w[3]) ck = 1'b0;
         check61("p61 rand");
      end
      io(1'b1, icsp_pkg::ADDR_SYS_CTRL, 8'h00);
      lo = 4'h0;
      pblk = 1'b1;
      perr = 1'b1;
      idle(1);
      perr = 1'b0;
      check61("par blocked");
      // A write while the clock enable is low must not land
      ce = 1'b0;
      io(1'b1, icsp_pkg::ADDR_SYS_CTRL, 8'h03);
      ce = 1'b1;
      check61("frozen");
      pblk = 1'b0;
      perr = 1'b1;
      idle(1);
      perr = 1'b0;
      pe = 1'b1;
      check61("par err");
      io(1'b1, icsp_pkg::ADDR_RTC_INDEX, 8'h80);
      mk = 1'b1;
      check61("masked");
      io(1'b1, icsp_pkg::ADDR_RTC_INDEX, 8'h00);
      mk = 1'b0;
      perr = 1'b1;
      io(1'b1, icsp_pkg::ADDR_SYS_CTRL, 8'h04);
      lo = 4'h4;
      pe = 1'b0;
      check61("par preset");
      perr = 1'b0;
      io(1'b1, icsp_pkg::ADDR_SYS_CTRL, 8'h00);
      lo = 4'h0;
      chk_n = 1'b0;
      ck = 1'b1;
      check61("chck set");
      chk_n = 1'b1;
      check61("chck held");
      io(1'b1, icsp_pkg::ADDR_SYS_CTRL, 8'h08);
      lo = 4'h8;
      ck = 1'b0;
      check61("chck clear");
      for (int i = 0; i < 3; i++) begin
         rfq = 1'b1;
         idle(4);
         rfq = 1'b0;
         rf = ~rf;
         check61("refresh");
      end
      // Mid-run reset with an armed window and a latched parity error
      io(1'b1, icsp_pkg::ADDR_CFG_INDEX, 8'h10);
      perr = 1'b1;
      idle(1);
      perr = 1'b0;
      rstn = 1'b0;
      idle(2);
      rstn = 1'b1;
      {rf, ck, pe, lo} = '0;
      check61("mid reset");
      rd(icsp_pkg::ADDR_CFG_DATA);
      chk(v, icsp_pkg::READ_IDLE, "unarmed after reset");
      io(1'b0, 16'h0062, 8'h00);
      got = 1'b0;
      repeat (4) begin
         @(posedge clk_sys);
         #1;
         got = got | io_rvalid;
      end
      chk({7'h00, got}, 8'h00, "unmapped");
      wrap_up();
   end
endmodule // indexed_config_and_sys_port_tb
